// [rtl/sfr_consts.svh]
// constants of the serial flash read front end
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// read opcodes
`define SFR_OP_NORMAL   8'h03
`define SFR_OP_FAST     8'h0B
`define SFR_OP_DUAL_IO  8'hBB
`define SFR_OP_QUAD_IO  8'hEB
`define SFR_OP_UID      8'h4B
`define SFR_OP_SFDP     8'h5A
`define SFR_OP_INFO     8'h68

// continuous read entry code, upper nibble of the mode field
`define SFR_MODE_CONT   4'hA

// line widths of a phase
`define SFR_LINES_1     3'h1
`define SFR_LINES_2     3'h2
`define SFR_LINES_4     3'h4

// last clock index of opcode and address phases
`define SFR_OP_LAST_1   6'h07
`define SFR_OP_LAST_4   6'h01
`define SFR_ADDR_LAST_1 6'h17
`define SFR_ADDR_LAST_2 6'h0B
`define SFR_ADDR_LAST_4 6'h05

// dummy and mode clock counts
`define SFR_FAST_DUMMY  5'h08
`define SFR_DUAL_MODE   3'h4
`define SFR_QUAD_MODE   3'h2

// reset values of the configuration defaults
`define SFR_DUAL_DUMMY_DEF 4'h4
`define SFR_QUAD_DUMMY_DEF 4'h6

// array spaces on the read port
`define SFR_SPACE_ARRAY 2'h0
`define SFR_SPACE_UID   2'h1
`define SFR_SPACE_SFDP  2'h2
`define SFR_SPACE_INFO  2'h3

`endif

// [rtl/sfr_pkg.sv]
// types of the serial flash read front end
package sfr_pkg;

  // command sequencer states
  typedef enum {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfr_state_type;

  // array space selector
  typedef logic [1:0] sfr_space_type;

endpackage

// [rtl/sfr_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sfr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // sfr_sync

// [rtl/sfr_toggle_rx.sv]
// toggle to pulse receiver for events crossing clock domains
`timescale 1ns/1ps
module sfr_toggle_rx (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // event
  input  wire logic tgl,
  output logic      pulse
);

  logic metaTgl_r;
  logic syncTgl_r;
  logic lastTgl_r;

  // synchronise, then compare against the previous level
  always_ff @(posedge clk) begin
    if (rst) begin
      metaTgl_r <= 1'b0;
      syncTgl_r <= 1'b0;
      lastTgl_r <= 1'b0;
      pulse     <= 1'b0;
    end else begin
      metaTgl_r <= tgl;
      syncTgl_r <= metaTgl_r;
      lastTgl_r <= syncTgl_r;
      pulse     <= syncTgl_r ^ lastTgl_r;
    end
  end

endmodule // sfr_toggle_rx

// [rtl/sfr_front_end.sv]
// serial flash read command front end, link and status logic
// Notes on behaviour
// - opcode 03h on the single input line, then three address bytes.
// - 24 address bits shift in; only the implemented low bits decode.
// - single-line data goes out MSB first; address steps per byte.
// - the address counter wraps past the top location to zero.
// - a read arriving while a write is in progress is ignored.
// - fast read 0Bh takes three address bytes and eight dummy clocks.
// - fast read data changes on falling clock edges after dummy.
// - quad opcode mode: 2 opcode, 6 address, configurable dummy clocks.
// - quad opcode framing also serves EBh, 4Bh, 5Ah and 68h.
// - hold pauses a selected transfer and keeps the sequence state.
// - while held the outputs float and the inputs are ignored.
// - hold is unavailable with the quad enable bit set.
// - dual I/O read takes address two bits per edge, MSB on line one.
// - dual I/O data goes two bits per falling edge, MSB on line one.
// - first four clocks after the dual address carry the mode field.
// - mode nibble 1010 enters continuous mode; next read skips opcode.
// - any other nibble leaves continuous mode; interface mode is kept.
// - dummy count includes the mode clocks.
// - quad I/O read in single-line opcode mode needs quad enable set.
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_front_end
  import sfr_pkg::*;
#(
  parameter int ADDR_W = 23
) (
  // system clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // configuration and status, system domain
  input  wire logic              writeInProgress,
  input  wire logic              quadEnableBit,
  input  wire logic              quadOpcodeMode,
  input  wire logic [3:0]        dualDummyCnt,
  input  wire logic [3:0]        quadDummyCnt,
  output logic                   frameActive,
  output logic                   contModeActive,
  output logic                   cmdIgnored,
  // serial link pins
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              holdN,
  input  wire logic [3:0]        ioIn,
  output logic      [3:0]        ioOut,
  output logic      [3:0]        ioOeN,
  // array read port, link clock domain
  output logic      [ADDR_W-1:0] memAddr,
  output sfr_space_type          memSpace,
  input  wire logic [7:0]        memData
);

  // configuration seen in the link domain
  logic [10:0]   cfgLink;
  logic          wipS;
  logic          qeS;
  logic          qpiS;
  logic [3:0]    dualDummyS;
  logic [3:0]    quadDummyS;

  // sequencer state
  sfr_state_type state_r;
  logic [5:0]    cnt_r;
  logic [23:0]   shift_r;
  logic [2:0]    addrLines_r;
  logic [2:0]    dataLines_r;
  logic [4:0]    dummy_r;
  logic [2:0]    modeClk_r;
  logic [2:0]    pos_r;
  logic          contMode_r;
  logic          contQuad_r;
  logic          ignTgl_r;

  // combinational helpers
  logic          holdActive;
  logic [23:0]   opShift;
  logic [23:0]   addrShift;
  logic [5:0]    opLast;
  logic [5:0]    addrLast;
  logic [5:0]    dummyLast;
  logic [3:0]    posSum;
  logic [7:0]    outByte;
  logic [7:0]    opSel;
  logic          qpiEff;
  logic          qeEff;
  logic          decOk;
  logic [2:0]    decAddrLines;
  logic [4:0]    decDummy;
  logic [2:0]    decModeClk;
  sfr_space_type decSpace;
  logic          opDone;
  logic          ignoreEvt;
  logic          modeEvt;

  // shift in one clock worth of bits, highest line first
  function automatic logic [23:0] shiftIn(input logic [23:0] sh,
                                          input logic [2:0]  w,
                                          input logic [3:0]  io);
    case (w)
      `SFR_LINES_2: shiftIn = {sh[21:0], io[1:0]};
      `SFR_LINES_4: shiftIn = {sh[19:0], io};
      default:      shiftIn = {sh[22:0], io[0]};
    endcase
  endfunction

  // configuration crosses into the link clock as quasi-static levels
  sfr_sync #(
    .WIDTH   (11),
    .RST_VAL ({3'h0, `SFR_DUAL_DUMMY_DEF, `SFR_QUAD_DUMMY_DEF})
  ) uCfgSync (
    .clk (sclk),
    .rst (1'b0),
    .d   ({writeInProgress, quadEnableBit, quadOpcodeMode,
           dualDummyCnt, quadDummyCnt}),
    .q   (cfgLink)
  );

  assign wipS       = cfgLink[10];
  assign qeS        = cfgLink[9];
  assign qpiS       = cfgLink[8];
  assign dualDummyS = cfgLink[7:4];
  assign quadDummyS = cfgLink[3:0];

  // hold only counts while quad enable and quad opcode mode are off
  assign holdActive = !holdN && !qeS && !qpiS;

  // shift values and phase lengths
  assign opShift   = shiftIn(shift_r, qpiS ? `SFR_LINES_4 : `SFR_LINES_1,
                             ioIn);
  assign addrShift = shiftIn(shift_r, addrLines_r, ioIn);
  assign opLast    = qpiS ? `SFR_OP_LAST_4 : `SFR_OP_LAST_1;
  assign dummyLast = {1'b0, dummy_r} - 6'h01;
  assign posSum    = {1'b0, pos_r} + {1'b0, dataLines_r};
  assign outByte   = memData << pos_r;

  // address phase length per line count
  always_comb begin
    case (addrLines_r)
      `SFR_LINES_2: addrLast = `SFR_ADDR_LAST_2;
      `SFR_LINES_4: addrLast = `SFR_ADDR_LAST_4;
      default:      addrLast = `SFR_ADDR_LAST_1;
    endcase
  end

  // in continuous mode the saved read stands in for the opcode
  assign opSel = contMode_r ? (contQuad_r ? `SFR_OP_QUAD_IO
                                          : `SFR_OP_DUAL_IO)
                            : opShift[7:0];
  assign qpiEff = contMode_r ? 1'b0 : qpiS;
  assign qeEff  = contMode_r ? 1'b1 : qeS;

  // opcode decode into phase shapes
  always_comb begin
    decOk        = 1'b0;
    decAddrLines = `SFR_LINES_1;
    decDummy     = 5'h00;
    decModeClk   = 3'h0;
    case (opSel)
      `SFR_OP_UID:  decSpace = `SFR_SPACE_UID;
      `SFR_OP_SFDP: decSpace = `SFR_SPACE_SFDP;
      `SFR_OP_INFO: decSpace = `SFR_SPACE_INFO;
      default:      decSpace = `SFR_SPACE_ARRAY;
    endcase
    if (qpiEff) begin
      case (opSel)
        `SFR_OP_FAST, `SFR_OP_QUAD_IO, `SFR_OP_UID, `SFR_OP_SFDP,
        `SFR_OP_INFO: begin
          decOk        = 1'b1;
          decAddrLines = `SFR_LINES_4;
          decDummy     = {1'b0, quadDummyS};
          if (opSel == `SFR_OP_QUAD_IO) begin
            decModeClk = `SFR_QUAD_MODE;
          end
        end
        default: decOk = 1'b0;
      endcase
    end else begin
      case (opSel)
        `SFR_OP_NORMAL: decOk = 1'b1;
        `SFR_OP_FAST, `SFR_OP_UID, `SFR_OP_SFDP,
        `SFR_OP_INFO: begin
          decOk    = 1'b1;
          decDummy = `SFR_FAST_DUMMY;
        end
        `SFR_OP_DUAL_IO: begin
          decOk        = 1'b1;
          decAddrLines = `SFR_LINES_2;
          decDummy     = {1'b0, dualDummyS};
          decModeClk   = `SFR_DUAL_MODE;
        end
        `SFR_OP_QUAD_IO: begin
          decOk        = qeEff;
          decAddrLines = `SFR_LINES_4;
          decDummy     = {1'b0, quadDummyS};
          decModeClk   = `SFR_QUAD_MODE;
        end
        default: decOk = 1'b0;
      endcase
    end
  end

  // opcode complete (or skipped) on this edge
  assign opDone = (state_r == ST_OPCODE) && !holdActive &&
                  (contMode_r || (cnt_r == opLast));

  // a valid read met while a write runs
  assign ignoreEvt = !csN && opDone && decOk && wipS;

  // last clock of the mode field
  assign modeEvt = !csN && !holdActive && (state_r == ST_DUMMY) &&
                   (modeClk_r != 3'h0) &&
                   (cnt_r == ({3'h0, modeClk_r} - 6'h01));

  // command sequencer; chip select high aborts it
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      state_r     <= ST_OPCODE;
      cnt_r       <= 6'h00;
      shift_r     <= 24'h000000;
      addrLines_r <= `SFR_LINES_1;
      dataLines_r <= `SFR_LINES_1;
      dummy_r     <= 5'h00;
      modeClk_r   <= 3'h0;
      pos_r       <= 3'h0;
      memAddr     <= '0;
      memSpace    <= `SFR_SPACE_ARRAY;
    end else if (!holdActive) begin
      case (state_r)
        ST_OPCODE: begin
          if (opDone) begin
            addrLines_r <= decAddrLines;
            dataLines_r <= decAddrLines;
            dummy_r     <= decDummy;
            modeClk_r   <= decModeClk;
            memSpace    <= decSpace;
            if (!decOk || wipS) begin
              state_r <= ST_IGNORE;
            end else if (contMode_r) begin
              // first address bits arrive on the first clock
              shift_r <= shiftIn(shift_r, decAddrLines, ioIn);
              cnt_r   <= 6'h01;
              state_r <= ST_ADDR;
            end else begin
              shift_r <= 24'h000000;
              cnt_r   <= 6'h00;
              state_r <= ST_ADDR;
            end
          end else begin
            shift_r <= opShift;
            cnt_r   <= cnt_r + 6'h01;
          end
        end
        ST_ADDR: begin
          shift_r <= addrShift;
          if (cnt_r == addrLast) begin
            memAddr <= addrShift[ADDR_W-1:0];
            cnt_r   <= 6'h00;
            pos_r   <= 3'h0;
            state_r <= (dummy_r == 5'h00) ? ST_DATA : ST_DUMMY;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_DUMMY: begin
          shift_r <= addrShift;
          if (cnt_r == dummyLast) begin
            pos_r   <= 3'h0;
            state_r <= ST_DATA;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_DATA: begin
          pos_r <= posSum[2:0];
          if (posSum[3]) begin
            memAddr <= memAddr + 1'b1;
          end
        end
        ST_IGNORE: state_r <= ST_IGNORE;
        default:   state_r <= ST_IGNORE;
      endcase
    end
  end

  // mode field decision and ignore events, kept across frames
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      contMode_r <= 1'b0;
      contQuad_r <= 1'b0;
      ignTgl_r   <= 1'b0;
    end else begin
      if (modeEvt) begin
        contMode_r <= (addrShift[7:4] == `SFR_MODE_CONT);
        contQuad_r <= (addrLines_r == `SFR_LINES_4);
      end
      if (ignoreEvt) begin
        ignTgl_r <= ~ignTgl_r;
      end
    end
  end

  // output lines change on the falling edge
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      ioOut <= 4'h0;
      ioOeN <= 4'hF;
    end else if (holdActive || state_r != ST_DATA) begin
      ioOeN <= 4'hF;
    end else begin
      case (dataLines_r)
        `SFR_LINES_2: begin
          ioOut <= {2'h0, outByte[7:6]};
          ioOeN <= 4'hC;
        end
        `SFR_LINES_4: begin
          ioOut <= outByte[7:4];
          ioOeN <= 4'h0;
        end
        default: begin
          ioOut <= {2'h0, outByte[7], 1'b0};
          ioOeN <= 4'hD;
        end
      endcase
    end
  end

  // link status back into the system domain
  sfr_sync #(
    .WIDTH   (2),
    .RST_VAL (2'h0)
  ) uStatSync (
    .clk (clk_sys),
    .rst (reset),
    .d   ({~csN, contMode_r}),
    .q   ({frameActive, contModeActive})
  );

  // ignored command event as a pulse
  sfr_toggle_rx uIgnRx (
    .clk   (clk_sys),
    .rst   (reset),
    .tgl   (ignTgl_r),
    .pulse (cmdIgnored)
  );

endmodule // sfr_front_end

// [verif/sfr_front_end_checker.sv]
// port assertions of the serial flash read front end
`timescale 1ns/1ps
module sfr_front_end_checker
  import sfr_pkg::*;
#(
  parameter int ADDR_W = 23
) (
  // system side
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              writeInProgress,
  input wire logic              quadEnableBit,
  input wire logic              quadOpcodeMode,
  input wire logic              frameActive,
  input wire logic              contModeActive,
  input wire logic              cmdIgnored,
  // link side
  input wire logic              sclk,
  input wire logic              csN,
  input wire logic              holdN,
  input wire logic [3:0]        ioOeN,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire sfr_space_type     memSpace
);
  // deselect floats the lines and clears the read port
  a_cs_float:
    assert property (@(posedge clk_sys) disable iff (reset)
      csN |-> ioOeN == 4'hF) else $error("lines driven while deselected");
  a_cs_port:
    assert property (@(posedge clk_sys) disable iff (reset)
      csN |-> memAddr == '0 && memSpace == '0) else $error("port not idle");
  // status follows the frame and reset
  a_frame_seen:
    assert property (@(posedge clk_sys) disable iff (reset)
      $fell(csN) |-> ##[1:4] frameActive) else $error("frame not seen");
  a_reset_quiet:
    assert property (@(posedge clk_sys) reset |=> !frameActive &&
      !contModeActive && !cmdIgnored) else $error("status alive in reset");
  // refused reads stay silent, one pulse each
  a_ign_pulse:
    assert property (@(posedge clk_sys) disable iff (reset)
      cmdIgnored |=> !cmdIgnored) else $error("ignore pulse too long");
  a_wip_silent:
    assert property (@(posedge clk_sys) disable iff (reset) writeInProgress
      && $past(writeInProgress, 8) |-> ioOeN == 4'hF) else $error("driven");
  // only single, dual or quad line groups are driven
  a_oe_code:
    assert property (@(posedge clk_sys) disable iff (reset)
      ioOeN inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("odd enables");
  // hold floats the outputs from the next falling edge
  a_hold_float:
    assert property (@(negedge sclk) disable iff (csN) !holdN &&
      !quadEnableBit && !quadOpcodeMode |=> ioOeN == 4'hF)
      else $error("output driven while held");
  // main scenarios reached
  c_cont: cover property (@(posedge clk_sys) $rose(contModeActive));
  c_ignored: cover property (@(posedge clk_sys) cmdIgnored);
  c_hold: cover property (@(negedge sclk) !csN && !holdN);
endmodule // sfr_front_end_checker

bind sfr_front_end sfr_front_end_checker #(.ADDR_W(ADDR_W)) i_chk (
  .clk_sys, .reset, .writeInProgress, .quadEnableBit, .quadOpcodeMode,
  .frameActive, .contModeActive, .cmdIgnored, .sclk, .csN, .holdN,
  .ioOeN, .memAddr, .memSpace);

// [verif/sfr_host_model.sv]
// host controller model driving the serial flash link
`timescale 1ns/1ps
module sfr_host_model (
  // link pins
  output logic            sclk,
  output logic            csN,
  output logic            holdN,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOeN
);
  localparam realtime HALF = 62.5;
  logic [3:0] hostDrv;
  logic [7:0] rxByte;
  event       got;

  // wire level: device where it drives, host value elsewhere
  assign ioIn = ~ioOeN & ioOut | ioOeN & hostDrv;

  // select starts low and rises at 1 ns, so the link logic sees a real
  // rising edge on its asynchronous clear whatever the start-up order
  initial begin
    sclk = 1'b0;
    csN = 1'b0;
    holdN = 1'b1;
    hostDrv = 4'h0;
    #1 csN = 1'b1;
  end

  // one clock, data set while low, clock idles low
  task automatic clk1(logic [3:0] d);
    hostDrv = d;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
  endtask

  // shift bits out msb first on one, two or four lines
  task automatic send(int lines, int n, logic [31:0] v);
    logic [3:0] d;
    repeat (n) begin
      d = 4'($urandom);
      if (lines == 1) d[0] = v[31];
      else if (lines == 2) d[1:0] = v[31:30];
      else d = v[31:28];
      v = v << lines;
      clk1(d);
    end
  endtask

  // collect one byte at rising edges
  task automatic recv(int lines);
    logic [7:0] r;
    r = 8'h00;
    repeat (8 / lines) begin
      hostDrv = 4'($urandom);
      #HALF;
      if (lines == 1) r = {r[6:0], ioIn[1]};
      else if (lines == 2) r = {r[5:0], ioIn[1:0]};
      else r = {r[3:0], ioIn};
      sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    rxByte = r;
    -> got;
  endtask

  // frame edges, select only while the clock is low
  task automatic start();
    #3.3 csN = 1'b0;
    #HALF;
  endtask
  task automatic stop();
    #HALF csN = 1'b1;
    #HALF;
  endtask
  task automatic tick2();
    repeat (2) clk1(4'($urandom));
  endtask
  // pause while the clock is low, garbage on the inputs
  task automatic pause(int n);
    holdN = 1'b0;
    repeat (n) clk1(4'($urandom));
    holdN = 1'b1;
  endtask
endmodule // sfr_host_model

// [verif/testbench.sv]
// self-checking bench of the serial flash read front end
`timescale 1ns/1ps
`include "sfr_consts.svh"
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin nFail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module testbench
  import sfr_pkg::*;
;
  logic          clk_sys, reset, writeInProgress, quadEnableBit;
  logic          quadOpcodeMode, frameActive, contModeActive, cmdIgnored;
  logic          sclk, csN, holdN;
  logic [3:0]    dualDummyCnt, quadDummyCnt, ioIn, ioOut, ioOeN;
  logic [22:0]   memAddr;
  sfr_space_type memSpace;
  logic [7:0]    memData, expB;
  logic [23:0]   ad;
  logic [7:0]    expQ[$];
  logic [7:0]    ops[5] = '{`SFR_OP_FAST, `SFR_OP_QUAD_IO, `SFR_OP_UID,
                            `SFR_OP_SFDP, `SFR_OP_INFO};
  int            sps[5] = '{0, 0, 1, 2, 3};
  int            nFail = 0, nTests = 0, nIgn = 0;

  // array content per space and address
  function automatic logic [7:0] memf(logic [22:0] a, logic [1:0] s);
    return a[7:0] ^ a[15:8] ^ {s, a[21:16]};
  endfunction
  assign memData = memf(memAddr, memSpace);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  sfr_front_end i_sfr_front_end (.clk_sys(clk_sys), .reset(reset),
    .writeInProgress(writeInProgress), .quadEnableBit(quadEnableBit),
    .quadOpcodeMode(quadOpcodeMode), .dualDummyCnt(dualDummyCnt),
    .quadDummyCnt(quadDummyCnt), .frameActive(frameActive),
    .contModeActive(contModeActive), .cmdIgnored(cmdIgnored), .sclk(sclk),
    .csN(csN), .holdN(holdN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN),
    .memAddr(memAddr), .memSpace(memSpace), .memData(memData));
  sfr_host_model i_sfr_host_model (.sclk(sclk), .csN(csN), .holdN(holdN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));

  // compare each collected byte with the oldest note
  always @(i_sfr_host_model.got) begin
    expB = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
    `CHK("read byte", expB, i_sfr_host_model.rxByte)
  end
  always @(negedge clk_sys) if (cmdIgnored === 1'b1) nIgn++;

  task automatic stopTest();
    if (nFail == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // config change while deselected, then two settling clocks
  task automatic cfg(logic write_in_progress_flag, logic qe, logic quad_opcode_mode);
    @(negedge clk_sys);
    writeInProgress = write_in_progress_flag;
    quadEnableBit = qe;
    quadOpcodeMode = quad_opcode_mode;
    i_sfr_host_model.tick2();
  endtask

  // one read frame; no opcode clocks when ol is zero
  task automatic rd(logic [7:0] op, int ol, int al, int dl, int dum,
                    logic [7:0] md, logic [23:0] a, int nb, int sp, bit hz);
    logic [22:0] p;
    p = a[22:0];
    repeat (nb) begin
      expQ.push_back(memf(p, 2'(sp)));
      p = p + 23'h1;
    end
    i_sfr_host_model.start();
    if (ol > 0) i_sfr_host_model.send(ol, 8 / ol, {op, 24'h0});
    if (hz) begin
      i_sfr_host_model.send(al, 12, {a, 8'h0});
      i_sfr_host_model.pause(3);
      i_sfr_host_model.send(al, 12, {a[11:0], 20'h0});
    end else i_sfr_host_model.send(al, 24 / al, {a, 8'h0});
    // lower mode nibble left to chance, as a floating line would be
    if (dum > 0) i_sfr_host_model.send(al, dum,
                   {md[7:4], 28'($urandom)});
    repeat (nb) i_sfr_host_model.recv(dl);
    i_sfr_host_model.stop();
  endtask

  // bounded wait for the continuous mode flag
  task automatic waitCont(logic ex);
    int k;
    k = 0;
    while (contModeActive !== ex && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    `CHK("continuous mode", ex, contModeActive)
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    nFail++;
    stopTest();
  end

  initial begin
    void'($urandom(32'h2968CB7F));
    reset = 1'b0;
    writeInProgress = 1'b0;
    quadEnableBit = 1'b0;
    quadOpcodeMode = 1'b0;
    dualDummyCnt = `SFR_DUAL_DUMMY_DEF;
    quadDummyCnt = `SFR_QUAD_DUMMY_DEF;
    // a clean rising edge, seen by the asynchronous clears as well
    #1 reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    cfg(1'b0, 1'b0, 1'b0);
    ad = {1'($urandom), 23'h7FFFFE};
    rd(`SFR_OP_NORMAL, 1, 1, 1, 0, 8'h00, ad, 4, 0, 0);
    // abort in mid-address, then fast read and a held read
    i_sfr_host_model.start();
    i_sfr_host_model.send(1, 12, {`SFR_OP_FAST, 24'h123456});
    i_sfr_host_model.stop();
    ad = 24'($urandom);
    rd(`SFR_OP_FAST, 1, 1, 1, 8, 8'h00, ad, 2, 0, 0);
    rd(`SFR_OP_NORMAL, 1, 1, 1, 0, 8'h00, ad, 2, 0, 1);
    // dual io read entering, keeping and leaving continuous mode
    rd(`SFR_OP_DUAL_IO, 1, 2, 2, 4, 8'hA3, ad, 2, 0, 0);
    waitCont(1'b1);
    rd(8'h00, 0, 2, 2, 4, 8'hA5, ad + 24'h10, 1, 0, 0);
    rd(8'h00, 0, 2, 2, 4, 8'h5A, ad, 1, 0, 0);
    waitCont(1'b0);
    // refused while a write runs
    cfg(1'b1, 1'b0, 1'b0);
    i_sfr_host_model.start();
    i_sfr_host_model.send(1, 40, {`SFR_OP_NORMAL, 24'($urandom)});
    i_sfr_host_model.stop();
    repeat (10) @(negedge clk_sys);
    `CHK("ignored reads", 1, nIgn)
    cfg(1'b0, 1'b1, 1'b0);
    rd(`SFR_OP_QUAD_IO, 1, 4, 4, 6, 8'h00, ad, 2, 0, 0);
    // quad opcode framing for each of 0Bh, EBh, 4Bh, 5Ah and 68h
    cfg(1'b0, 1'b0, 1'b1);
    foreach (ops[i]) begin
      rd(ops[i], 4, 4, 4, 6, 8'h00, 24'h3, 2, sps[i], 0);
    end
    rd(`SFR_OP_QUAD_IO, 4, 4, 4, 6, 8'hA0, ad, 1, 0, 0);
    rd(8'h00, 0, 4, 4, 6, 8'h00, ad, 1, 0, 0);
    waitCont(1'b0);
    repeat (20) @(negedge clk_sys);
    `CHK("bytes left", 0, expQ.size())
    stopTest();
  end
endmodule // testbench
